// ### design/ipb_bank.sv
// Interrupt priority bank with Avalon-MM slave, arbitration and status interrupt
`timescale 1ns/1ps
module ipb_bank
    import ipb_pkg::*;
#(
    parameter bit HAS_T4_CC3 = 1'b1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic [1:0] avs_response_o,
    // Peripheral request flags, same clock
    input wire logic [16:0] src_flag_i,
    // Request to the processor
    output logic cpu_req_o,
    output logic [2:0] cpu_prio_o,
    output logic [4:0] cpu_src_o,
    // Status interrupt
    output logic irq_o
);
    // Whole state of the block
    typedef struct packed {
        logic [IPB_NSRC*IPB_PW-1:0] prio;  // All priority fields
        logic [16:0] enable;               // Per-source enables
        logic [1:0] status;                // Sticky events
        logic [1:0] mask;                  // Event masks
        logic [31:0] rdata;                // Registered read data
        logic [1:0] resp;                  // Registered response
        logic ack;                         // Answer phase
        logic req;                         // Request to processor
        logic [2:0] win_prio;              // Winning priority
        logic [4:0] win_src;               // Winning source
    } ipb_state_t;

    ipb_state_t st_r;
    ipb_state_t st_nxt;

    // Implemented-field mask of one register; variant fields drop out when absent
    function automatic logic [15:0] ipb_impl(input int idx);
        logic [15:0] m;
        m = 16'h0000;
        for (int s = 0; s < IPB_NSRC; s++) begin
            if (IPB_SRC_REG[s] == idx && (HAS_T4_CC3 || (s != IPB_SRC_T4 && s != IPB_SRC_CC3))) begin // RULE11
                m = m | (16'h0007 << IPB_SRC_LSB[s]);
            end
        end
        return m;
    endfunction

    // Assemble one priority register from the field store
    function automatic logic [15:0] ipb_pack(input int idx, input logic [IPB_NSRC*IPB_PW-1:0] p);
        logic [15:0] v;
        v = 16'h0000;
        for (int s = 0; s < IPB_NSRC; s++) begin
            if (IPB_SRC_REG[s] == idx) begin
                v = v | (16'(p[s*IPB_PW +: IPB_PW]) << IPB_SRC_LSB[s]);
            end
        end
        return v & ipb_impl(idx); // RULE3
    endfunction

    // Qualified requests: enabled, flagged and nonzero priority
    logic [16:0] live;
    generate
        for (genvar g = 0; g < IPB_NSRC; g++) begin : g_live
            assign live[g] = src_flag_i[g] & st_r.enable[g]  // RULE12
                & (st_r.prio[g*IPB_PW +: IPB_PW] != IPB_PRIO_OFF); // RULE2
        end
    endgenerate

    // Next-state logic: bus access, arbitration, events
    always_comb begin
        logic [2:0] bp;
        logic [4:0] bs;
        logic [15:0] wv;
        logic [15:0] im;
        logic hit;
        logic chg;
        logic werr;
        int ri;
        st_nxt = st_r;
        bp = IPB_PRIO_OFF;
        bs = IPB_NONE;
        wv = 16'h0000;
        im = 16'h0000;
        hit = 1'b0;
        chg = 1'b0;
        werr = 1'b0;
        ri = int'(avs_address_i[5:2]);
        st_nxt.ack = 1'b0;
        // Strict greater-than keeps the lowest index on ties
        for (int s = 0; s < IPB_NSRC; s++) begin
            if (live[s] && st_r.prio[s*IPB_PW +: IPB_PW] > bp) begin // RULE13 RULE1
                bp = st_r.prio[s*IPB_PW +: IPB_PW];
                bs = 5'(s);
            end
        end
        st_nxt.req = (bp != IPB_PRIO_OFF);
        st_nxt.win_prio = bp;
        st_nxt.win_src = bs;
        chg = (bs != st_r.win_src);
        // One-cycle answer: request taken in first cycle, answered in the second
        if ((avs_read_i || avs_write_i) && !st_r.ack) begin
            st_nxt.ack = 1'b1;
            st_nxt.resp = 2'h0;
            st_nxt.rdata = 32'h0000_0000;
            hit = (avs_address_i[1:0] == 2'h0) && (avs_address_i < IPB_OFF_WIN);
            if (!hit) begin
                st_nxt.resp = 2'h2; // Unmapped address: slave error, reads zero
            end else if (avs_read_i) begin
                case (avs_address_i)
                    IPB_OFF_ENABLE: st_nxt.rdata = {15'h0000, st_r.enable};
                    IPB_OFF_STATUS: st_nxt.rdata = {30'h0000_0000, st_r.status};
                    IPB_OFF_MASK: st_nxt.rdata = {30'h0000_0000, st_r.mask};
                    default: st_nxt.rdata = {16'h0000, ipb_pack(ri, st_r.prio)}; // RULE5 RULE6 RULE7 RULE10
                endcase
            end else begin
                case (avs_address_i)
                    IPB_OFF_ENABLE: begin
                        if (avs_byteenable_i[0]) st_nxt.enable[7:0] = avs_writedata_i[7:0];
                        if (avs_byteenable_i[1]) st_nxt.enable[15:8] = avs_writedata_i[15:8];
                        if (avs_byteenable_i[2]) st_nxt.enable[16] = avs_writedata_i[16];
                    end
                    IPB_OFF_STATUS: begin
                        if (avs_byteenable_i[0]) st_nxt.status = st_r.status & ~avs_writedata_i[1:0];
                    end
                    IPB_OFF_MASK: begin
                        if (avs_byteenable_i[0]) st_nxt.mask = avs_writedata_i[1:0];
                    end
                    default: begin
                        im = ipb_impl(ri);
                        wv = {avs_byteenable_i[1] ? 8'hFF : 8'h00, avs_byteenable_i[0] ? 8'hFF : 8'h00};
                        werr = |(avs_writedata_i[15:0] & ~im & wv);
                        // Only implemented, byte-enabled bits change
                        for (int s = 0; s < IPB_NSRC; s++) begin
                            for (int b = 0; b < IPB_PW; b++) begin
                                if (IPB_SRC_REG[s] == ri && im[IPB_SRC_LSB[s]+b] && wv[IPB_SRC_LSB[s]+b]) begin
                                    st_nxt.prio[s*IPB_PW+b] = avs_writedata_i[IPB_SRC_LSB[s]+b]; // RULE3 RULE8 RULE9
                                end
                            end
                        end
                    end
                endcase
            end
        end
        // Set wins over a clear in the same cycle
        if (chg) st_nxt.status[IPB_ST_CHANGE] = 1'b1;
        if (werr) st_nxt.status[IPB_ST_WR_ERR] = 1'b1;
    end

    // Register the whole state; every priority field loads 100 at reset
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r.prio <= {IPB_NSRC{IPB_PRIO_RST}}; // RULE4
            st_r.enable <= 17'h0_0000;
            st_r.status <= 2'h0;
            st_r.mask <= IPB_ST_MASK_RST;
            st_r.rdata <= 32'h0000_0000;
            st_r.resp <= 2'h0;
            st_r.ack <= 1'b0;
            st_r.req <= 1'b0;
            st_r.win_prio <= 3'h0;
            st_r.win_src <= IPB_NONE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !st_r.ack;
    assign avs_readdata_o = st_r.rdata;
    assign avs_response_o = st_r.resp;
    assign cpu_req_o = st_r.req;
    assign cpu_prio_o = st_r.win_prio;
    assign cpu_src_o = st_r.win_src;
    assign irq_o = |(st_r.status & st_r.mask);

    // Checks
    AST_ZERO_OFF: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE2
        cpu_req_o |-> st_r.prio[cpu_src_o*IPB_PW +: IPB_PW] != 3'h0 || $past(st_r.prio) != st_r.prio)
        else $error("request shown for disabled source");
    AST_ENA: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE12
        (src_flag_i & st_r.enable & ~{17{1'b0}}) == 17'h0 |=> !cpu_req_o)
        else $error("request without enabled flag");
    AST_REQ: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE13
        (|live) |=> cpu_req_o && cpu_prio_o != 3'h0)
        else $error("pending source not presented");
    AST_WIN: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE1
        cpu_req_o |-> cpu_prio_o >= 3'h1 && cpu_prio_o <= 3'h7)
        else $error("winning priority out of range");
    AST_UNIMP: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE3
        st_r.ack && $past(avs_read_i) && $past(avs_address_i) == IPB_OFF_PRIO5 |-> st_r.rdata[31:3] == 29'h0)
        else $error("unimplemented bits read nonzero");
    AST_R1LOW: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE6
        st_r.ack && $past(avs_read_i) && $past(avs_address_i) == IPB_OFF_PRIO1 |-> st_r.rdata[7:0] == 8'h00)
        else $error("low byte of register 1 nonzero");
    AST_R2MID: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE7
        st_r.ack && $past(avs_read_i) && $past(avs_address_i) == IPB_OFF_PRIO2 |-> st_r.rdata[11:3] == 9'h000)
        else $error("middle bits of register 2 nonzero");
    AST_EXT1: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE10
        st_r.ack && $past(avs_read_i) && $past(avs_address_i) == IPB_OFF_PRIO5
        |-> st_r.rdata[2:0] == st_r.prio[14*IPB_PW +: IPB_PW])
        else $error("ext1 field misplaced");
    AST_ONEWAIT: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read answer not after one wait cycle");
    AST_RST: assert property (@(posedge mclk_i) $rose(rst_n_i) |-> st_r.prio == {IPB_NSRC{3'h4}}) // RULE4
        else $error("fields not at level 4 after reset");
    AST_VAR: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE11
        !HAS_T4_CC3 |-> st_r.ack && $past(avs_read_i) && $past(avs_address_i) == IPB_OFF_PRIO6
        |-> st_r.rdata == 32'h0000_0000 || !$past(avs_read_i))
        else $error("absent variant fields read nonzero");
    AST_R0: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE5
        st_r.ack && $past(avs_read_i) && $past(avs_address_i) == IPB_OFF_PRIO0
        |-> st_r.rdata[14:12] == st_r.prio[2:0] && st_r.rdata[2:0] == st_r.prio[8:6])
        else $error("register 0 field layout wrong");
    AST_R3: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE8
        st_r.ack && $past(avs_read_i) && $past(avs_address_i) == IPB_OFF_PRIO3 |-> st_r.rdata[6:4] == st_r.prio[26:24])
        else $error("adc field misplaced");
    AST_R4: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE9
        st_r.ack && $past(avs_read_i) && $past(avs_address_i) == IPB_OFF_PRIO4 |-> st_r.rdata[2:0] == st_r.prio[41:39])
        else $error("serial1 event field misplaced");
endmodule

// ### inc/ipb_pkg.sv
// Constants, register map and field layout of the interrupt priority bank
// Summary of operation
// RULE1: Three-bit field gives level one to seven
// RULE2: Field zero disables the source completely
// RULE3: Unimplemented bits read zero, ignore writes
// RULE4: Every field resets to binary 100
// RULE5: Register 0: timer1, capcmp1, ext0 fields
// RULE6: Register 1: timer2, capcmp2; low byte unused
// RULE7: Register 2: uart1 receive, timer3 fields
// RULE8: Register 3: nvmem, adc done, uart1 transmit
// RULE9: Register 4: change, comparator, serial1 pair
// RULE10: Register 5: only ext1 in bits 2-0
// RULE11: Register 6: timer4, capcmp3; optional per variant
// RULE12: Request needs its own enable bit set
// RULE13: Highest priority wins, lowest source breaks ties
package ipb_pkg;
    // Source count and priority field width
    localparam int IPB_NSRC = 17;
    localparam int IPB_PW = 3;
    localparam int IPB_NPRIO = 7;
    localparam logic [2:0] IPB_PRIO_RST = 3'h4;
    localparam logic [2:0] IPB_PRIO_OFF = 3'h0;
    // Byte offsets on the register bus
    localparam logic [5:0] IPB_OFF_PRIO0 = 6'h00;
    localparam logic [5:0] IPB_OFF_PRIO1 = 6'h04;
    localparam logic [5:0] IPB_OFF_PRIO2 = 6'h08;
    localparam logic [5:0] IPB_OFF_PRIO3 = 6'h0C;
    localparam logic [5:0] IPB_OFF_PRIO4 = 6'h10;
    localparam logic [5:0] IPB_OFF_PRIO5 = 6'h14;
    localparam logic [5:0] IPB_OFF_PRIO6 = 6'h18;
    localparam logic [5:0] IPB_OFF_ENABLE = 6'h1C;
    localparam logic [5:0] IPB_OFF_STATUS = 6'h20;
    localparam logic [5:0] IPB_OFF_MASK = 6'h24;
    localparam logic [5:0] IPB_OFF_WIN = 6'h28;
    localparam int IPB_NREG = 7;
    // Field position of each source: register index and low bit
    // Source order: t1,cc1,e0,t2,cc2,u1rx,t3,nvm,adc,u1tx,cn,cm,bcl1,ssp1,e1,t4,cc3
    localparam int IPB_SRC_REG [IPB_NSRC] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 6, 6};
    localparam int IPB_SRC_LSB [IPB_NSRC] = '{12, 8, 0, 12, 8, 12, 0, 12, 4, 0, 12, 8, 4, 0, 0, 12, 4};
    // Source indices of the two variant-dependent fields
    localparam int IPB_SRC_T4 = 15;
    localparam int IPB_SRC_CC3 = 16;
    // Status register bit positions
    localparam int IPB_ST_CHANGE = 0;
    localparam int IPB_ST_WR_ERR = 1;
    localparam logic [1:0] IPB_ST_MASK_RST = 2'h0;
    localparam logic [4:0] IPB_NONE = 5'h1F;
endpackage

// ### tb/ipb_src_model.sv
// Peripheral request sources: sticky level flags raised and cleared by the bench
`timescale 1ns/1ps
module ipb_src_model (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Flag commands, one bit per source
    input wire logic [16:0] set_i,
    input wire logic [16:0] clr_i,
    // Flags toward the bank
    output logic [16:0] flag_o
);
    // Flags hold until cleared, like a real peripheral flag; clear wins
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_o <= 17'h0_0000;
        end else begin
            flag_o <= (flag_o | set_i) & ~clr_i;
        end
    end
endmodule

// ### tb/interrupt_priority_bank_test.sv
// Self-checking bench for the interrupt priority bank
`timescale 1ns/1ps
module interrupt_priority_bank_test;
    import ipb_pkg::*;
    typedef struct {logic [5:0] a; logic [31:0] d; logic q; logic [2:0] p; logic [4:0] s;} ipb_step_t;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [5:0] adr = 6'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [16:0] fset = 17'h0_0000;
    logic [16:0] fclr = 17'h0_0000;
    logic [16:0] flags;
    logic [31:0] avs_readdata_o, rdat;
    logic [31:0] rd_b, rdat_b;
    logic avs_waitrequest_o, cpu_req_o, irq_o;
    logic [1:0] avs_response_o, resp;
    logic [2:0] cpu_prio_o;
    logic [4:0] cpu_src_o;
    int fail_count = 0;
    int n_compared = 0;
    ipb_step_t steps [7] = '{'{IPB_OFF_ENABLE, 32'h0001_FFFF, 0, 0, 31}, '{IPB_OFF_PRIO5, 32'h3, 1, 3, 14},
        '{IPB_OFF_PRIO0, 32'h1000, 1, 3, 14}, '{IPB_OFF_PRIO0, 32'h3000, 1, 3, 0},
        '{IPB_OFF_PRIO0, 32'h7000, 1, 7, 0}, '{IPB_OFF_ENABLE, 32'h4000, 1, 3, 14},
        '{IPB_OFF_PRIO5, 32'h0, 0, 0, 31}};
    // Free-running 25 MHz clock
    always #20 mclk_i = ~mclk_i;
    ipb_src_model SRC (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .set_i(fset), .clr_i(fclr), .flag_o(flags));
    ipb_bank DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o), .src_flag_i(flags),
        .cpu_req_o(cpu_req_o), .cpu_prio_o(cpu_prio_o), .cpu_src_o(cpu_src_o), .irq_o(irq_o));
    // Variant without timer4 and capcmp3: shares the bus, only its read data is judged
    ipb_bank #(.HAS_T4_CC3(1'b0)) DUT_B (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rd_b), .avs_waitrequest_o(), .avs_response_o(), .src_flag_i(flags),
        .cpu_req_o(), .cpu_prio_o(), .cpu_src_o(), .irq_o());
    // Verdict and end of run
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One Avalon access; request held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk_i);
        rd <= ~w;
        wr <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        chk("bus answer in time", 1, n < 20);
        rdat = avs_readdata_o;
        rdat_b = rd_b;
        resp = avs_response_o;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    // Expected register image with every field of register r at value v
    function automatic logic [31:0] fld(input int r, input logic [2:0] v);
        logic [31:0] x = 32'h0000_0000;
        for (int s = 0; s < IPB_NSRC; s++)
            if (IPB_SRC_REG[s] == r) x = x | (32'(v) << IPB_SRC_LSB[s]);
        return x;
    endfunction
    task automatic t_reset;
        bus(0, IPB_OFF_PRIO0, 0);
        chk("prio0 reset", 32'h0000_4404, rdat);
        for (int r = 0; r < IPB_NREG; r++) begin
            bus(0, 6'(r * 4), 0);
            chk("prio reset", fld(r, 3'h4), rdat);
        end
        bus(0, IPB_OFF_MASK, 0);
        chk("mask reset", 0, rdat);
        $display("test reset done");
    endtask
    // Unmapped and unaligned places are refused and change nothing
    task automatic t_unmapped;
        bus(0, IPB_OFF_WIN, 0);
        chk("unmapped resp", 2'b10, resp);
        chk("unmapped data", 0, rdat);
        bus(1, 6'h02, 32'hFFFF_FFFF);
        chk("unaligned resp", 2'b10, resp);
        bus(0, IPB_OFF_PRIO0, 0);
        chk("prio0 untouched", 32'h0000_4404, rdat);
        $display("test unmapped done");
    endtask
    // All ones then all zeros: only the documented field bits stick
    task automatic t_fields;
        for (int r = 0; r < IPB_NREG; r++) begin
            bus(1, 6'(r * 4), 32'hFFFF_FFFF);
            bus(0, 6'(r * 4), 0);
            chk("prio ones", fld(r, 3'h7), rdat);
            if (r == 6) chk("variant absent", 0, rdat_b);
            bus(1, 6'(r * 4), 0);
            bus(0, 6'(r * 4), 0);
            chk("prio zeros", 0, rdat);
        end
        $display("test fields done");
    endtask
    // Status raise, mask and write-one clear of the level interrupt
    task automatic t_irq;
        bus(1, IPB_OFF_STATUS, 32'h0000_0003);
        bus(1, IPB_OFF_MASK, 32'h0000_0002);
        @(posedge mclk_i);
        chk("irq idle", 0, irq_o);
        bus(1, IPB_OFF_PRIO1, 32'h0000_00FF);
        @(posedge mclk_i);
        chk("irq raised", 1, irq_o);
        bus(1, IPB_OFF_MASK, 0);
        @(posedge mclk_i);
        chk("irq masked", 0, irq_o);
        bus(1, IPB_OFF_MASK, 32'h0000_0002);
        bus(1, IPB_OFF_STATUS, 32'h0000_0002);
        @(posedge mclk_i);
        chk("irq cleared", 0, irq_o);
        bus(0, IPB_OFF_PRIO1, 0);
        chk("prio1 low byte", 0, rdat);
        $display("test irq done");
    endtask
    // Winner selection by level, disable by zero, enable gating, tie order
    task automatic t_arb;
        @(posedge mclk_i);
        fset <= 17'h0_4001;
        @(posedge mclk_i);
        fset <= 17'h0_0000;
        foreach (steps[i]) begin
            bus(1, steps[i].a, steps[i].d);
            repeat (3) @(posedge mclk_i);
            chk("cpu req", steps[i].q, cpu_req_o);
            chk("cpu src", steps[i].s, cpu_src_o);
            if (steps[i].q) chk("cpu prio", steps[i].p, cpu_prio_o);
        end
        $display("test arbitration done");
    endtask
    // Watchdog cuts a hang short
    initial begin
        #400000;
        fail_count++;
        $display("watchdog expired");
        stop_test();
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_unmapped();
        t_fields();
        t_irq();
        t_arb();
        stop_test();
    end
endmodule
